/* design/port_watch.sv */
module port_watch #(
    parameter int UW = 9
) (
    input  wire logic          clock,       // Core clock
    input  wire logic          nrst,        // Sync reset, low
    thr_if.snk                 thr,         // Selected thresholds
    input  wire logic [UW-1:0] usage,       // Buffers held by port
    output logic               active,      // Port counts as active
    output logic               over_drop,   // Ingress limit reached
    output logic               pause_on,    // Flow control applied
    output logic               pause_send,  // Pulse: pause/backpressure
    output logic               resume_send  // Pulse: pause value 1
);
    sbm_pkg::pause_state_t state;       // Flow-control state
    sbm_pkg::pause_state_t next_state;  // Next state
    logic next_send;                    // Next pause pulse
    logic next_resume;                  // Next resume pulse

    // Levels are whole 128-byte buffers, so compare counts directly
    assign active    = usage >= UW'(sbm_pkg::ACTIVE_BUFS);
    assign over_drop = usage >= UW'(thr.drop_lvl);
    assign pause_on  = state == sbm_pkg::HELD;

    // Hysteresis between pause level and resume level
    always_comb
    begin
        next_state  = state;
        next_send   = 1'b0;
        next_resume = 1'b0;
        unique case (state)
            sbm_pkg::FLOWING:
            begin
                if (usage >= UW'(thr.pause_lvl))
                begin
                    next_state = sbm_pkg::HELD;
                    next_send  = 1'b1;
                end
            end
            sbm_pkg::HELD:
            begin
                // Release only once usage is back down
                if (usage <= UW'(thr.resume_lvl))
                begin
                    next_state  = sbm_pkg::FLOWING;
                    next_resume = 1'b1;
                end
            end
        endcase
    end

    // Registers
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            state       <= sbm_pkg::FLOWING;
            pause_send  <= 1'b0;
            resume_send <= 1'b0;
        end
        else
        begin
            state       <= next_state;
            pause_send  <= next_send;
            resume_send <= next_resume;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    property p_pause_on_level;
        !pause_on && usage >= UW'(thr.pause_lvl) |=> pause_on && pause_send;
    endproperty
    a_pause_on_level: assert property (p_pause_on_level)
        else $error("pause not raised at level");

    property p_resume_value;
        pause_on && usage <= UW'(thr.resume_lvl) |=> !pause_on && resume_send;
    endproperty
    a_resume_value: assert property (p_resume_value)
        else $error("resume not sent at level");
endmodule : port_watch

/* design/sbm_pkg.sv */
package sbm_pkg;
    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_CFG    = 16'h1c00;
    localparam logic [15:0] IDX_DROP   = 16'h1c01;
    localparam logic [15:0] IDX_PAUSE  = 16'h1c02;
    localparam logic [15:0] IDX_RESUME = 16'h1c03;
    localparam logic [15:0] IDX_CNT0   = 16'h1c05;
    localparam int          NPORT      = 3;

    // Field positions in buffer_policy_config
    localparam int CFG_TEST   = 6;
    localparam int CFG_STRICT = 5;
    localparam int CFG_PACE_H = 4;
    localparam int CFG_PACE_L = 2;
    localparam int CFG_YELLOW = 1;
    localparam int CFG_RED    = 0;
    localparam logic [31:0] CFG_MASK = 32'h0000_007f;

    // Threshold fields: low half for 2-3 active, high half for 0-1
    localparam int LOW_H  = 15;
    localparam int LOW_L  = 8;
    localparam int HIGH_H = 7;
    localparam int HIGH_L = 0;
    localparam logic [31:0] LVL_MASK = 32'h0000_ffff;

    // Reset values
    localparam logic [31:0] CFG_RST    = 32'h0000_0000;
    localparam logic [31:0] DROP_RST   = 32'h0000_4964;
    localparam logic [31:0] PAUSE_RST  = 32'h0000_213c;
    localparam logic [31:0] RESUME_RST = 32'h0000_0307;

    // Drop counters
    localparam logic [31:0] CNT_TEST = 32'h07ff_fffc;
    localparam logic [31:0] CNT_MAX  = 32'hffff_ffff;

    // Threshold units and port activity
    localparam int BUF_BYTES    = 128;
    localparam int ACTIVE_BUFS  = 36;
    localparam int MANY_ACTIVE  = 2;

    // Pause value sent to release the link partner
    localparam logic [15:0] RESUME_QUANTA = 16'h0001;

    typedef enum logic [0:0] {
        FLOWING = 1'b0,
        HELD    = 1'b1
    } pause_state_t;
endpackage : sbm_pkg

/* design/switch_buffer_admission_control.sv */
module switch_buffer_admission_control #(
    parameter int UW = 9
) (
    input  wire logic                 clock,          // Core clock 125 MHz
    input  wire logic                 nrst,           // Sync reset, low
    input  wire logic                 psel,           // APB select
    input  wire logic                 penable,        // APB access phase
    input  wire logic                 pwrite,         // APB write
    input  wire logic [15:0]          paddr,          // APB byte address
    input  wire logic [31:0]          pwdata,         // APB write data
    output logic      [31:0]          prdata,         // APB read data
    output logic                      pready,         // APB ready
    output logic                      pslverr,        // APB error
    input  wire logic [2:0][UW-1:0]   usage,          // Buffers per port
    input  wire logic [2:0]           space_drop,     // Pulse: drop for room
    input  wire logic [2:0]           pkt_valid,      // Pulse: packet colored
    input  wire logic [2:0]           pkt_yellow,     // Packet is Yellow
    input  wire logic [2:0]           pkt_red,        // Packet is Red
    input  wire logic [2:0]           random_hit,     // Random discard chose
    output logic                      strict_order,   // Fixed priority serve
    output logic      [2:0]           pace_en,        // Egress pacing
    output logic      [2:0]           discard,        // Pulse: meter discard
    output logic      [2:0]           port_active,    // Port active
    output logic      [2:0]           over_drop,      // Ingress limit hit
    output logic      [2:0]           pause_on,       // Flow control held
    output logic      [2:0]           pause_send,     // Pulse: send pause
    output logic      [2:0]           resume_send,    // Pulse: pause value 1
    output logic      [15:0]          resume_quanta   // Pause value on resume
);
    logic [31:0]      cfg;           // buffer_policy_config
    logic [31:0]      drop_lvl;      // ingress_drop_thresholds
    logic [31:0]      pause_lvl;     // pause_trigger_thresholds
    logic [31:0]      resume_lvl;    // Resume levels
    logic [2:0][31:0] drop_cnt;      // Per-source drop counters
    logic [31:0]      next_cfg;
    logic [31:0]      next_drop_lvl;
    logic [31:0]      next_pause_lvl;
    logic [31:0]      next_resume_lvl;
    logic [2:0][31:0] next_drop_cnt;
    logic [31:0]      next_prdata;
    logic [2:0]       next_discard;
    logic [1:0]       n_active;      // Active port count
    logic             many;          // Two or three active
    logic             setup;         // APB setup cycle
    logic             access;        // APB access cycle
    logic [2:0]       dropped;       // Drop event per port

    thr_if thr ();

    // Map a byte address to one of our registers
    function automatic logic addr_hit(input logic [15:0] a);
        logic [15:0] idx;
        idx = {2'h0, a[15:2]};
        addr_hit = a[1:0] == 2'h0 &&
                   idx >= sbm_pkg::IDX_CFG &&
                   idx <= sbm_pkg::IDX_CNT0 + 16'h0002 &&
                   idx != sbm_pkg::IDX_RESUME + 16'h0001;
    endfunction : addr_hit

    // Index of a byte address
    function automatic logic [15:0] idx_of(input logic [15:0] a);
        idx_of = {2'h0, a[15:2]};
    endfunction : idx_of

    // Saturating add of one event
    function automatic logic [31:0] sat_inc(input logic [31:0] v,
                                            input logic        inc);
        sat_inc = (inc && v != sbm_pkg::CNT_MAX) ? v + 32'h0000_0001 : v;
    endfunction : sat_inc

    // Zero-wait slave: every access finishes in one access cycle
    assign setup   = psel && !penable;
    assign access  = psel && penable;
    assign pready  = 1'b1;
    assign pslverr = access && !addr_hit(paddr);

    // Configuration fields steer the fabric directly
    assign strict_order  = cfg[sbm_pkg::CFG_STRICT];
    assign pace_en       = cfg[sbm_pkg::CFG_PACE_H:sbm_pkg::CFG_PACE_L];
    assign resume_quanta = sbm_pkg::RESUME_QUANTA;

    // Count active ports; none active behaves like one
    always_comb
    begin
        n_active = 2'h0;
        for (int p = 0; p < sbm_pkg::NPORT; p++)
        begin
            n_active = n_active + {1'b0, port_active[p]};
        end
        many = n_active >= 2'(sbm_pkg::MANY_ACTIVE);
    end

    // Pick the low or high half of each threshold register
    always_comb
    begin
        if (many)
        begin
            thr.drop_lvl   = drop_lvl[sbm_pkg::LOW_H:sbm_pkg::LOW_L];
            thr.pause_lvl  = pause_lvl[sbm_pkg::LOW_H:sbm_pkg::LOW_L];
            thr.resume_lvl = resume_lvl[sbm_pkg::LOW_H:sbm_pkg::LOW_L];
        end
        else
        begin
            thr.drop_lvl   = drop_lvl[sbm_pkg::HIGH_H:sbm_pkg::HIGH_L];
            thr.pause_lvl  = pause_lvl[sbm_pkg::HIGH_H:sbm_pkg::HIGH_L];
            thr.resume_lvl = resume_lvl[sbm_pkg::HIGH_H:sbm_pkg::HIGH_L];
        end
    end

    // One watcher per port on the shared thresholds
    generate
        for (genvar p = 0; p < sbm_pkg::NPORT; p++)
        begin : g_port
            port_watch #(.UW(UW)) u_watch (
                .clock       (clock),
                .nrst        (nrst),
                .thr         (thr.snk),
                .usage       (usage[p]),
                .active      (port_active[p]),
                .over_drop   (over_drop[p]),
                .pause_on    (pause_on[p]),
                .pause_send  (pause_send[p]),
                .resume_send (resume_send[p])
            );
        end
    endgenerate

    // Meter discards when enabled in cfg: Red always, Yellow only when random picks it
    always_comb
    begin
        next_discard = pkt_valid &
            ((pkt_red & {3{cfg[sbm_pkg::CFG_RED]}}) |
             (pkt_yellow & random_hit & {3{cfg[sbm_pkg::CFG_YELLOW]}}));
        dropped = space_drop | next_discard;
    end

    // Writes land in the access cycle; reserved bits never stored
    always_comb
    begin
        next_cfg        = cfg;
        next_drop_lvl   = drop_lvl;
        next_pause_lvl  = pause_lvl;
        next_resume_lvl = resume_lvl;
        // Misaligned or unmapped writes are dropped, never aliased
        if (access && pwrite && addr_hit(paddr))
        begin
            unique case (idx_of(paddr))
                sbm_pkg::IDX_CFG:
                    next_cfg = pwdata & sbm_pkg::CFG_MASK;
                sbm_pkg::IDX_DROP:
                    next_drop_lvl = pwdata & sbm_pkg::LVL_MASK;
                sbm_pkg::IDX_PAUSE:
                    next_pause_lvl = pwdata & sbm_pkg::LVL_MASK;
                sbm_pkg::IDX_RESUME:
                    next_resume_lvl = pwdata & sbm_pkg::LVL_MASK;
                default:             next_cfg = cfg;
            endcase
        end
    end

    // Counters: the read clears in the setup cycle, and an event in
    // the same cycle is kept so no drop is lost to the read
    always_comb
    begin
        logic [31:0] base;
        base = 32'h0000_0000;
        for (int p = 0; p < sbm_pkg::NPORT; p++)
        begin
            base = drop_cnt[p];
            if (setup && !pwrite && addr_hit(paddr) &&
                idx_of(paddr) == sbm_pkg::IDX_CNT0 + 16'(p))
            begin
                // Test mode preloads CNT_TEST (07FF_FFFCh) instead of zero on the read
                base = cfg[sbm_pkg::CFG_TEST] ? sbm_pkg::CNT_TEST
                                              : 32'h0000_0000;
            end
            next_drop_cnt[p] = sat_inc(base, dropped[p]);
        end
    end

    // Read data captured in setup so it is steady for the access
    always_comb
    begin
        next_prdata = prdata;
        if (setup && !pwrite && !addr_hit(paddr))
        begin
            // Refused reads return zero and touch no counter
            next_prdata = 32'h0000_0000;
        end
        else if (setup && !pwrite)
        begin
            unique case (idx_of(paddr))
                sbm_pkg::IDX_CFG:    next_prdata = cfg;
                sbm_pkg::IDX_DROP:   next_prdata = drop_lvl;
                sbm_pkg::IDX_PAUSE:  next_prdata = pause_lvl;
                sbm_pkg::IDX_RESUME: next_prdata = resume_lvl;
                sbm_pkg::IDX_CNT0:   next_prdata = drop_cnt[0];
                sbm_pkg::IDX_CNT0 + 16'h0001: next_prdata = drop_cnt[1];
                sbm_pkg::IDX_CNT0 + 16'h0002: next_prdata = drop_cnt[2];
                default:             next_prdata = 32'h0000_0000;
            endcase
        end
    end

    // Registers
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            cfg        <= sbm_pkg::CFG_RST;
            drop_lvl   <= sbm_pkg::DROP_RST;
            pause_lvl  <= sbm_pkg::PAUSE_RST;
            resume_lvl <= sbm_pkg::RESUME_RST;
            drop_cnt   <= '0;
            prdata     <= 32'h0000_0000;
            discard    <= 3'h0;
        end
        else
        begin
            cfg        <= next_cfg;
            drop_lvl   <= next_drop_lvl;
            pause_lvl  <= next_pause_lvl;
            resume_lvl <= next_resume_lvl;
            drop_cnt   <= next_drop_cnt;
            prdata     <= next_prdata;
            discard    <= next_discard;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    property p_test_load;
        setup && !pwrite && addr_hit(paddr) &&
        idx_of(paddr) == sbm_pkg::IDX_CNT0 &&
        cfg[sbm_pkg::CFG_TEST] && !dropped[0]
        |=> drop_cnt[0] == sbm_pkg::CNT_TEST;
    endproperty
    a_test_load: assert property (p_test_load)
        else $error("counter not loaded with test value");

    property p_clear_read;
        setup && !pwrite && addr_hit(paddr) &&
        idx_of(paddr) == sbm_pkg::IDX_CNT0 + 16'h0001 &&
        !cfg[sbm_pkg::CFG_TEST] && !dropped[1]
        |=> drop_cnt[1] == 32'h0000_0000 && prdata == $past(drop_cnt[1]);
    endproperty
    a_clear_read: assert property (p_clear_read)
        else $error("counter not cleared on read");

    property p_saturate;
        drop_cnt[2] == sbm_pkg::CNT_MAX && !setup |=> drop_cnt[2] ==
            sbm_pkg::CNT_MAX;
    endproperty
    a_saturate: assert property (p_saturate)
        else $error("counter wrapped");

    property p_strict;
        access && pwrite && addr_hit(paddr) &&
        idx_of(paddr) == sbm_pkg::IDX_CFG
        |=> strict_order == $past(pwdata[sbm_pkg::CFG_STRICT]);
    endproperty
    a_strict: assert property (p_strict)
        else $error("queue order not taken from write");

    property p_pace;
        access && pwrite && addr_hit(paddr) &&
        idx_of(paddr) == sbm_pkg::IDX_CFG
        |=> pace_en == $past(pwdata[sbm_pkg::CFG_PACE_H:sbm_pkg::CFG_PACE_L]);
    endproperty
    a_pace: assert property (p_pace)
        else $error("pacing enables not taken from write");

    // A refused write must leave cfg, drop_lvl and pause_lvl alone
    property p_refused;
        access && pwrite && !addr_hit(paddr)
        |=> $stable(cfg) && $stable(drop_lvl) && $stable(pause_lvl);
    endproperty
    a_refused: assert property (p_refused)
        else $error("refused write changed a register");

    property p_red;
        pkt_valid[0] && pkt_red[0] && cfg[sbm_pkg::CFG_RED] |=> discard[0];
    endproperty
    a_red: assert property (p_red)
        else $error("red packet not discarded");

    property p_yellow;
        pkt_valid[1] && pkt_yellow[1] && !pkt_red[1] &&
        !(random_hit[1] && cfg[sbm_pkg::CFG_YELLOW]) |=> !discard[1];
    endproperty
    a_yellow: assert property (p_yellow)
        else $error("yellow discarded without random pick");

    property p_threshold_pick;
        n_active <= 2'h1 |-> thr.drop_lvl ==
            drop_lvl[sbm_pkg::HIGH_H:sbm_pkg::HIGH_L];
    endproperty
    a_threshold_pick: assert property (p_threshold_pick)
        else $error("high drop level not used when quiet");
endmodule : switch_buffer_admission_control

/* design/thr_if.sv */
interface thr_if;
    logic [7:0] drop_lvl;    // Selected per-ingress drop limit
    logic [7:0] pause_lvl;   // Selected pause trigger level
    logic [7:0] resume_lvl;  // Selected resume level

    modport src (output drop_lvl, output pause_lvl, output resume_lvl);
    modport snk (input drop_lvl, input pause_lvl, input resume_lvl);
endinterface : thr_if

/* test/testbench.sv */
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    // One pending read result: data and error flag
    typedef struct packed {
        logic [31:0] data;  // Expected read data
        logic        err;   // Expected slave error
    } note_t;

    logic            clock      = 1'b0;  // Core clock, 8 ns
    logic            nrst       = 1'b0;  // Sync reset, low
    logic            psel       = 1'b0;  // APB select
    logic            penable    = 1'b0;  // APB access phase
    logic            pwrite     = 1'b0;  // APB direction
    logic [15:0]     paddr      = '0;    // APB byte address
    logic [31:0]     pwdata     = '0;    // APB write data
    logic [2:0][8:0] usage      = '0;    // Buffers per port
    logic [2:0]      space_drop = '0;    // Drop for room
    logic [2:0]      pkt_valid  = '0;    // Metered packet
    logic [2:0]      pkt_yellow = '0;    // Yellow color
    logic [2:0]      pkt_red    = '0;    // Red color
    logic [2:0]      random_hit = '0;    // Random discard pick
    logic [31:0]     prdata;             // APB read data
    logic            pready;             // APB ready
    logic            pslverr;            // APB error
    logic            strict_order;       // Fixed priority
    logic [2:0]      pace_en;            // Egress pacing
    logic [2:0]      discard;            // Meter discard
    logic [2:0]      port_active;        // Active ports
    logic [2:0]      over_drop;          // Limit reached
    logic [2:0]      pause_on;           // Flow control held
    logic [2:0]      pause_send;         // Pause pulse
    logic [2:0]      resume_send;        // Resume pulse
    logic [15:0]     resume_quanta;      // Resume pause value
    note_t           notes[$];           // Pending read results
    note_t           cur;                // Note under compare
    int              mismatches = 0;     // Failed compares
    int              n_checks   = 0;     // All compares
    int              cycles     = 0;     // Hang guard
    logic [31:0]     cnt_exp[3] = '{default: '0}; // Drop count model
    logic [31:0]     v;                  // Random word
    logic [2:0]      pv, py, pr, ph, sd, de, disc_exp;
    int              c;                  // Color pick

    always #4 clock = ~clock;

    switch_buffer_admission_control #(.UW(9)) uut (
        .clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .usage(usage), .space_drop(space_drop), .pkt_valid(pkt_valid),
        .pkt_yellow(pkt_yellow), .pkt_red(pkt_red),
        .random_hit(random_hit), .strict_order(strict_order),
        .pace_en(pace_en), .discard(discard), .port_active(port_active),
        .over_drop(over_drop), .pause_on(pause_on),
        .pause_send(pause_send), .resume_send(resume_send),
        .resume_quanta(resume_quanta)
    );

    task check(input string name, input logic [31:0] seen,
               input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task final_report();
        if (mismatches == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report

    // Registers sit one word apart, so the byte address is index times four
    function automatic logic [15:0] ba(input logic [15:0] idx);
        return idx << 2;
    endfunction : ba

    // Setup then access; held until pready is seen high at an edge
    task apb_xfer(input logic [15:0] a, input logic w, input logic [31:0] d);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        do
            @(posedge clock);
        while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb_xfer

    task apb_write(input logic [15:0] a, input logic [31:0] d);
        apb_xfer(a, 1'b1, d);
    endtask : apb_write

    // The expectation is queued first; the monitor compares it
    task apb_read(input logic [15:0] a, input logic [31:0] d, input logic e);
        notes.push_back('{data: d, err: e});
        apb_xfer(a, 1'b0, 32'h0);
    endtask : apb_read

    // Combinational levels: checked just after the inputs land
    task lvl(input logic [8:0] u0, u1, u2, input logic [2:0] act, over);
        @(posedge clock);
        usage <= {u2, u1, u0};
        #1;
        check("port_active", port_active, act);
        check("over_drop", over_drop, over);
    endtask : lvl

    // Flow control answers one edge after usage changes (port 0 only)
    task pstep(input logic [8:0] u0, u1, u2, input logic s, o, r);
        @(posedge clock);
        usage <= {u2, u1, u0};
        @(posedge clock);
        #1;
        check("pause_send", pause_send[0], s);
        check("pause_on", pause_on[0], o);
        check("resume_send", resume_send[0], r);
    endtask : pstep

    // Read monitor: old values are sampled here, before the driver's NBAs
    always @(posedge clock)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            if (notes.size() == 0)
                check("read note", 32'h1, 32'h0);
            else
            begin
                cur = notes.pop_front();
                check("prdata", prdata, cur.data);
                check("pslverr", pslverr, cur.err);
            end
        end
    end

    // Hang guard; the whole run needs a few hundred cycles
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            final_report();
        end
    end

    initial
    begin
        void'($urandom(32'hbb89));
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        apb_read(ba(sbm_pkg::IDX_CFG), sbm_pkg::CFG_RST, 1'b0);
        apb_read(ba(sbm_pkg::IDX_DROP), 32'h0000_4964, 1'b0);
        apb_read(ba(sbm_pkg::IDX_PAUSE), 32'h0000_213c, 1'b0);
        apb_read(ba(sbm_pkg::IDX_RESUME), 32'h0000_0307, 1'b0);
        for (int p = 0; p < 3; p++)
            apb_read(ba(16'(sbm_pkg::IDX_CNT0 + p)), 32'h0, 1'b0);
        // Random config words; reserved bits must read back as zero
        for (int i = 0; i < 6; i++)
        begin
            v = $urandom;
            v[5] = i[0];
            apb_write(ba(sbm_pkg::IDX_CFG), v);
            apb_read(ba(sbm_pkg::IDX_CFG), v & 32'h0000_007f, 1'b0);
            check("strict_order", strict_order, v[5]);
            check("pace_en", pace_en, v[4:2]);
        end
        apb_write(ba(sbm_pkg::IDX_CFG), 32'h0);
        // Hole in the map and a misaligned address are refused
        apb_read(ba(16'h1c04), 32'h0, 1'b1);
        apb_write(ba(16'h1c04), $urandom);
        apb_read(16'h7001, 32'h0, 1'b1);
        apb_write(16'h7001, $urandom | 32'h0000_0020);
        apb_read(ba(sbm_pkg::IDX_CFG), 32'h0, 1'b0);
        v = $urandom;
        apb_write(ba(sbm_pkg::IDX_DROP), {v[31:16], 16'h4964});
        apb_read(ba(sbm_pkg::IDX_DROP), 32'h0000_4964, 1'b0);
        apb_write(ba(sbm_pkg::IDX_PAUSE), {v[15:0], 16'h213c});
        apb_read(ba(sbm_pkg::IDX_PAUSE), 32'h0000_213c, 1'b0);
        // Drop limit: 64h with one active port, 49h with two or three
        lvl(9'd99, 9'd0, 9'd0, 3'b001, 3'b000);
        lvl(9'd100, 9'd0, 9'd0, 3'b001, 3'b001);
        lvl(9'd72, 9'd36, 9'd0, 3'b011, 3'b000);
        lvl(9'd73, 9'd36, 9'd0, 3'b011, 3'b001);
        lvl(9'd73, 9'd35, 9'd0, 3'b001, 3'b000);
        lvl(9'd73, 9'd40, 9'd40, 3'b111, 3'b001);
        // No active port: the high field must apply, not the low
        apb_write(ba(sbm_pkg::IDX_DROP), 32'h0000_4920);
        lvl(9'd32, 9'd0, 9'd0, 3'b000, 3'b001);
        lvl(9'd31, 9'd0, 9'd0, 3'b000, 3'b000);
        apb_write(ba(sbm_pkg::IDX_DROP), 32'h0000_4964);
        // Pause at 3Ch alone, release at 07h; then 21h and 03h with many
        // Port 0 was left held by the drop-level steps, so it resumes here
        pstep(9'd0, 9'd0, 9'd0, 1'b0, 1'b0, 1'b1);
        pstep(9'd59, 9'd0, 9'd0, 1'b0, 1'b0, 1'b0);
        pstep(9'd60, 9'd0, 9'd0, 1'b1, 1'b1, 1'b0);
        pstep(9'd60, 9'd0, 9'd0, 1'b0, 1'b1, 1'b0);
        pstep(9'd8, 9'd0, 9'd0, 1'b0, 1'b1, 1'b0);
        pstep(9'd7, 9'd0, 9'd0, 1'b0, 1'b0, 1'b1);
        check("resume_quanta", resume_quanta, 32'h1);
        pstep(9'd32, 9'd40, 9'd40, 1'b0, 1'b0, 1'b0);
        pstep(9'd33, 9'd40, 9'd40, 1'b1, 1'b1, 1'b0);
        pstep(9'd4, 9'd40, 9'd40, 1'b0, 1'b1, 1'b0);
        pstep(9'd3, 9'd40, 9'd40, 1'b0, 1'b0, 1'b1);
        pstep(9'd0, 9'd0, 9'd0, 1'b0, 1'b0, 1'b0);
        // Every yellow/red drop setting against random colored traffic
        for (int m = 0; m < 4; m++)
        begin
            apb_write(ba(sbm_pkg::IDX_CFG), 32'(m));
            for (int k = 0; k < 16; k++)
            begin
                @(posedge clock);
                pv = 3'($urandom);
                ph = 3'($urandom);
                sd = 3'($urandom);
                for (int p = 0; p < 3; p++)
                begin
                    c = $urandom % 3;
                    py[p] = (c == 1);
                    pr[p] = (c == 2);
                end
                if (k == 15)
                begin
                    pv = '0;
                    sd = '0;
                end
                pkt_valid  <= pv;
                pkt_yellow <= py;
                pkt_red    <= pr;
                random_hit <= ph;
                space_drop <= sd;
                de = pv & ((pr & {3{m[0]}}) | (py & ph & {3{m[1]}}));
                for (int p = 0; p < 3; p++)
                    cnt_exp[p] += 32'(sd[p] | de[p]);
                #1;
                if (k > 0)
                    check("discard", discard, disc_exp);
                disc_exp = de;
            end
        end
        for (int p = 0; p < 3; p++)
        begin
            apb_read(ba(16'(sbm_pkg::IDX_CNT0 + p)), cnt_exp[p], 1'b0);
            apb_read(ba(16'(sbm_pkg::IDX_CNT0 + p)), 32'h0, 1'b0);
        end
        // Counter test: a read loads the test value instead of zero
        apb_write(ba(sbm_pkg::IDX_CFG), 32'h0000_0040);
        @(posedge clock);
        space_drop <= 3'b111;
        repeat (2) @(posedge clock);
        space_drop <= 3'b000;
        for (int p = 0; p < 3; p++)
        begin
            apb_read(ba(16'(sbm_pkg::IDX_CNT0 + p)), 32'h2, 1'b0);
            apb_read(ba(16'(sbm_pkg::IDX_CNT0 + p)), 32'h07ff_fffc, 1'b0);
        end
        apb_write(ba(sbm_pkg::IDX_CFG), 32'h0);
        for (int p = 0; p < 3; p++)
        begin
            apb_read(ba(16'(sbm_pkg::IDX_CNT0 + p)), 32'h07ff_fffc, 1'b0);
            apb_read(ba(16'(sbm_pkg::IDX_CNT0 + p)), 32'h0, 1'b0);
        end
        // Reset in mid-run restores the pause levels
        apb_write(ba(sbm_pkg::IDX_PAUSE), 32'h0000_1234);
        @(posedge clock);
        nrst <= 1'b0;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        apb_read(ba(sbm_pkg::IDX_PAUSE), 32'h0000_213c, 1'b0);
        repeat (2) @(posedge clock);
        check("open notes", 32'(notes.size()), 32'h0);
        final_report();
    end
endmodule : testbench
